// file: hdl/lspa_ctrl.sv
// command decoder holding partial area, scroll, access control and idle state
`timescale 1ns/10ps
module lspa_ctrl (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic byte_valid_in,
    input wire logic is_data_in,
    input wire logic [7:0] byte_in,
    input wire logic frame_start_in,
    input wire logic orient_flip_in,
    input wire logic partial_mode_in,
    input wire logic [7:0] line_in,
    input wire logic [11:0] pixel_in,
    output logic [7:0] partial_start_line_out,
    output logic [7:0] partial_end_line_out,
    output logic [7:0] top_fixed_lines_out,
    output logic [7:0] scroll_lines_out,
    output logic [7:0] bottom_fixed_lines_out,
    output logic top_fixed_present_out,
    output logic bottom_fixed_present_out,
    output logic [7:0] scroll_start_out,
    output logic scroll_active_out,
    output logic page_bottom_up_out,
    output logic col_right_left_out,
    output logic write_page_dir_out,
    output logic scan_bottom_up_out,
    output logic bgr_order_out,
    output logic vert_invert_out,
    output logic ram_read_bottom_up_out,
    output logic regions_rotated_out,
    output logic line_off_out,
    output logic ram_access_en_out,
    output logic idle_mode_out,
    output logic [11:0] pixel_out
);
    import lspa_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [1:0] frame_sync_r;
    logic [1:0] orient_sync_r;
    logic [1:0] pmode_sync_r;
    logic frame_prev_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            frame_sync_r <= 2'b00;
            orient_sync_r <= 2'b00;
            pmode_sync_r <= 2'b00;
            frame_prev_r <= 1'b0;
        end else begin
            frame_sync_r <= {frame_sync_r[0], frame_start_in};
            orient_sync_r <= {orient_sync_r[0], orient_flip_in};
            pmode_sync_r <= {pmode_sync_r[0], partial_mode_in};
            frame_prev_r <= frame_sync_r[1];
        end
    end
    logic frame_edge;
    assign frame_edge = frame_sync_r[1] & ~frame_prev_r;

    // ==========================================================
    // opcode and parameter counting
    logic cmd_stb;
    logic dat_stb;
    assign cmd_stb = byte_valid_in & ~is_data_in;
    assign dat_stb = byte_valid_in & is_data_in;

    logic [7:0] opcode_r;
    lspa_pstate_e pstate_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            opcode_r <= 8'h00;
            pstate_r <= LSPA_IDLE;
        end else if (cmd_stb) begin
            opcode_r <= byte_in;
            pstate_r <= LSPA_P1;
        end else if (dat_stb) begin
            unique case (pstate_r)
                LSPA_IDLE: pstate_r <= LSPA_IDLE;
                LSPA_P1: pstate_r <= LSPA_P2;
                LSPA_P2: pstate_r <= LSPA_DONE;
                LSPA_DONE: pstate_r <= LSPA_DONE; // extras ignored, except the third scroll layout byte, which p3 takes in this state
                default: pstate_r <= LSPA_IDLE;
            endcase
        end
    end
    logic p1;
    logic p2;
    logic p3;
    assign p1 = dat_stb & (pstate_r == LSPA_P1);
    assign p2 = dat_stb & (pstate_r == LSPA_P2);
    assign p3 = dat_stb & (pstate_r == LSPA_DONE) & (opcode_r == SCROLL_LAYOUT_CMD);
    // third byte of the scroll layout must not re-arm, so a 4th byte is dropped
    logic layout_done_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            layout_done_r <= 1'b0;
        end else if (cmd_stb) begin
            layout_done_r <= 1'b0;
        end else if (p3) begin
            layout_done_r <= 1'b1;
        end
    end

    // ==========================================================
    // partial area
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            partial_start_line_out <= PARTIAL_START_RST;
            partial_end_line_out <= PARTIAL_END_RST;
        end else begin
            if (p1 && opcode_r == PARTIAL_AREA_CMD) begin
                partial_start_line_out <= byte_in;
            end
            if (p2 && opcode_r == PARTIAL_AREA_CMD) begin
                partial_end_line_out <= byte_in;
            end
        end
    end

    // ==========================================================
    // scroll layout
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            top_fixed_lines_out <= TOP_FIXED_RST;
            scroll_lines_out <= SCROLL_LINES_RST;
            bottom_fixed_lines_out <= BOTTOM_FIXED_RST;
            top_fixed_present_out <= 1'b0;
            bottom_fixed_present_out <= 1'b1;
        end else begin
            if (p1 && opcode_r == SCROLL_LAYOUT_CMD) begin
                top_fixed_lines_out <= byte_in;
                top_fixed_present_out <= (byte_in != 8'h00);
            end
            if (p2 && opcode_r == SCROLL_LAYOUT_CMD) begin
                scroll_lines_out <= byte_in;
            end
            if (p3 && !layout_done_r) begin
                bottom_fixed_lines_out <= byte_in;
                bottom_fixed_present_out <= (byte_in != 8'h00);
            end
        end
    end

    // ==========================================================
    // scroll start, latched at frame start
    logic [7:0] scroll_pend_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scroll_pend_r <= SCROLL_START_RST;
        end else if (p1 && opcode_r == SCROLL_START_CMD) begin
            scroll_pend_r <= byte_in;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scroll_start_out <= SCROLL_START_RST;
        end else if (frame_edge) begin
            // avoids tearing mid-frame
            scroll_start_out <= scroll_pend_r;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scroll_active_out <= 1'b0;
        end else if (cmd_stb && (byte_in == NORMAL_MODE_CMD || byte_in == PARTIAL_MODE_CMD)) begin
            scroll_active_out <= 1'b0;
        end else if (cmd_stb && byte_in == SCROLL_START_CMD) begin
            scroll_active_out <= 1'b1;
        end
    end

    // ==========================================================
    // memory access control
    logic [7:0] mac_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mac_r <= MAC_RST;
        end else if (p1 && opcode_r == MEM_ACCESS_CTRL_CMD) begin
            mac_r <= byte_in & MAC_USED_MASK;
        end
    end
    // orientation flip swaps what top and bottom mean
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            page_bottom_up_out <= 1'b0;
            col_right_left_out <= 1'b0;
            write_page_dir_out <= 1'b0;
            scan_bottom_up_out <= 1'b0;
            bgr_order_out <= 1'b0;
            vert_invert_out <= 1'b0;
            ram_read_bottom_up_out <= 1'b0;
            regions_rotated_out <= 1'b0;
        end else begin
            page_bottom_up_out <= mac_r[MAC_PAGE_BIT] ^ orient_sync_r[1];
            col_right_left_out <= mac_r[MAC_COL_BIT];
            write_page_dir_out <= mac_r[MAC_DIR_BIT];
            scan_bottom_up_out <= mac_r[MAC_SCAN_BIT] ^ orient_sync_r[1];
            bgr_order_out <= mac_r[MAC_BGR_BIT];
            vert_invert_out <= mac_r[MAC_INV_BIT];
            ram_read_bottom_up_out <= mac_r[MAC_SCAN_BIT] ^ mac_r[MAC_INV_BIT] ^ orient_sync_r[1];
            regions_rotated_out <= mac_r[MAC_SCAN_BIT];
        end
    end

    // ==========================================================
    // idle mode; 0x34/0x35 fall through untouched
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idle_mode_out <= 1'b0;
        end else if (cmd_stb && byte_in == REDUCED_COLOR_ON_CMD) begin
            idle_mode_out <= 1'b1;
        end else if (cmd_stb && byte_in == REDUCED_COLOR_OFF_CMD) begin
            idle_mode_out <= 1'b0;
        end
    end

    // ==========================================================
    // per-line blanking and pixel reduction
    logic in_area;
    assign in_area = (line_in >= partial_start_line_out) && (line_in <= partial_end_line_out);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            line_off_out <= 1'b0;
            ram_access_en_out <= 1'b1;
            pixel_out <= 12'h000;
        end else begin
            line_off_out <= pmode_sync_r[1] & ~in_area;
            ram_access_en_out <= ~(pmode_sync_r[1] & ~in_area);
            if (pmode_sync_r[1] && !in_area) begin
                pixel_out <= 12'h000;
            end else if (idle_mode_out) begin
                pixel_out <= {{4{pixel_in[11]}}, {4{pixel_in[7]}}, {4{pixel_in[3]}}};
            end else begin
                pixel_out <= pixel_in;
            end
        end
    end

    // ==========================================================
    // checks
    AST_PART_START: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        p1 && opcode_r == PARTIAL_AREA_CMD |=> partial_start_line_out == $past(byte_in))
        else $error("partial start not stored");
    AST_LINE_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        pmode_sync_r[1] && !in_area |=> line_off_out && !ram_access_en_out)
        else $error("outside line not blanked");
    AST_BOTTOM_PRESENT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        bottom_fixed_present_out == (bottom_fixed_lines_out != 8'h00))
        else $error("bottom presence mismatch");
    AST_MAC_RSVD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        mac_r[2:1] == 2'b00)
        else $error("reserved access bits set");
    AST_READ_DIR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ##1 ram_read_bottom_up_out
            == ($past(mac_r[4]) ^ $past(mac_r[0]) ^ $past(orient_sync_r[1])))
        else $error("read direction wrong");
    AST_SCROLL_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !frame_edge |=> $stable(scroll_start_out))
        else $error("scroll start changed mid frame");
    AST_SCROLL_EXIT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cmd_stb && (byte_in == NORMAL_MODE_CMD || byte_in == PARTIAL_MODE_CMD)
            |=> !scroll_active_out)
        else $error("scroll mode not left");
    AST_TOP_PRESENT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        top_fixed_present_out == (top_fixed_lines_out != 8'h00))
        else $error("top presence mismatch");
    AST_IDLE_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cmd_stb && byte_in == REDUCED_COLOR_OFF_CMD |=> !idle_mode_out)
        else $error("idle mode not left");
    AST_ROTATE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ##1 regions_rotated_out == $past(mac_r[MAC_SCAN_BIT]))
        else $error("region rotation wrong");
    AST_IDLE_ON: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cmd_stb && byte_in == REDUCED_COLOR_ON_CMD |=> idle_mode_out ##1 idle_mode_out
            || $past(cmd_stb))
        else $error("idle mode not entered");
    COV_PARTIAL: cover property (@(posedge clk_in) p2 && opcode_r == PARTIAL_AREA_CMD);
    COV_LAYOUT: cover property (@(posedge clk_in) p3 && !layout_done_r);
    COV_SCROLL: cover property (@(posedge clk_in) frame_edge && scroll_active_out);
    COV_IDLE: cover property (@(posedge clk_in) cmd_stb && byte_in == REDUCED_COLOR_ON_CMD);
    COV_BLANK: cover property (@(posedge clk_in) line_off_out);
endmodule : lspa_ctrl

// file: shared/lspa_pkg.sv
// constants for the scroll, partial area and access control command decoder
package lspa_pkg;
    // ==========================================================
    // command opcodes
    localparam logic [7:0] PARTIAL_AREA_CMD = 8'h30;
    localparam logic [7:0] SCROLL_LAYOUT_CMD = 8'h33;
    localparam logic [7:0] TEST_A_CMD = 8'h34;
    localparam logic [7:0] TEST_B_CMD = 8'h35;
    localparam logic [7:0] MEM_ACCESS_CTRL_CMD = 8'h36;
    localparam logic [7:0] SCROLL_START_CMD = 8'h37;
    localparam logic [7:0] REDUCED_COLOR_OFF_CMD = 8'h38;
    localparam logic [7:0] REDUCED_COLOR_ON_CMD = 8'h39;
    localparam logic [7:0] PARTIAL_MODE_CMD = 8'h12;
    localparam logic [7:0] NORMAL_MODE_CMD = 8'h13;
    // ==========================================================
    // access control field positions
    localparam int MAC_PAGE_BIT = 7;
    localparam int MAC_COL_BIT = 6;
    localparam int MAC_DIR_BIT = 5;
    localparam int MAC_SCAN_BIT = 4;
    localparam int MAC_BGR_BIT = 3;
    localparam int MAC_INV_BIT = 0;
    localparam logic [7:0] MAC_USED_MASK = 8'hf9;
    // ==========================================================
    // reset values
    localparam logic [7:0] PARTIAL_START_RST = 8'h00;
    localparam logic [7:0] PARTIAL_END_RST = 8'h00;
    localparam logic [7:0] TOP_FIXED_RST = 8'h00;
    localparam logic [7:0] SCROLL_LINES_RST = 8'h00;
    localparam logic [7:0] BOTTOM_FIXED_RST = 8'h53;
    localparam logic [7:0] SCROLL_START_RST = 8'h00;
    localparam logic [7:0] MAC_RST = 8'h00;
    // parameter counter states
    typedef enum logic [3:0] {
        LSPA_IDLE = 4'b0001,
        LSPA_P1 = 4'b0010,
        LSPA_P2 = 4'b0100,
        LSPA_DONE = 4'b1000
    } lspa_pstate_e;
endpackage : lspa_pkg

// file: tb/lspa_host.sv
// host model issuing command and parameter bytes to the decoder
`timescale 1ns/10ps
module lspa_host (
    input wire logic clk_in,
    output logic byte_valid_out,
    output logic is_data_out,
    output logic [7:0] byte_out
);
    initial begin
        byte_valid_out = 1'b0;
        is_data_out = 1'b0;
        byte_out = 8'h00;
    end
    // ==========================================================
    // opcode then n parameters back to back, first one in p[7:0]
    task automatic send(input logic [7:0] cmd, input int n, input logic [31:0] p);
        @(posedge clk_in);
        byte_valid_out <= 1'b1;
        is_data_out <= 1'b0;
        byte_out <= cmd;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            is_data_out <= 1'b1;
            byte_out <= p[8*i +: 8];
        end
        @(posedge clk_in);
        byte_valid_out <= 1'b0;
        // released bus must not keep showing the last byte
        byte_out <= ~byte_out;
    endtask : send
endmodule : lspa_host

// file: tb/tb.sv
// self-checking bench for the scroll, partial area and access control decoder
`timescale 1ns/10ps
module tb;
    import lspa_pkg::*;
    logic clk_in, rst_n_in, byte_valid_in, is_data_in, frame_start_in;
    logic orient_flip_in, partial_mode_in;
    logic [7:0] byte_in, line_in, ps, pe, tf, sl, bf, ss, a, b, m;
    logic [11:0] pixel_in, px;
    logic top_p, bot_p, sact, pg, cl, wd, sc, bgr, vi, rd, rot, loff, ram_en, idle, o;
    int n_mismatch = 0;
    int cmp_count = 0;
    integer seed = 51560;
    lspa_host i_lspa_host (.clk_in(clk_in), .byte_valid_out(byte_valid_in),
        .is_data_out(is_data_in), .byte_out(byte_in));
    lspa_ctrl i_lspa_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .byte_valid_in(byte_valid_in), .is_data_in(is_data_in), .byte_in(byte_in),
        .frame_start_in(frame_start_in), .orient_flip_in(orient_flip_in),
        .partial_mode_in(partial_mode_in), .line_in(line_in), .pixel_in(pixel_in),
        .partial_start_line_out(ps), .partial_end_line_out(pe), .top_fixed_lines_out(tf),
        .scroll_lines_out(sl), .bottom_fixed_lines_out(bf), .top_fixed_present_out(top_p),
        .bottom_fixed_present_out(bot_p), .scroll_start_out(ss), .scroll_active_out(sact),
        .page_bottom_up_out(pg), .col_right_left_out(cl), .write_page_dir_out(wd),
        .scan_bottom_up_out(sc), .bgr_order_out(bgr), .vert_invert_out(vi),
        .ram_read_bottom_up_out(rd), .regions_rotated_out(rot), .line_off_out(loff),
        .ram_access_en_out(ram_en), .idle_mode_out(idle), .pixel_out(px));
    // ==========================================================
    // helpers
    function automatic logic [11:0] idle_px(input logic [11:0] p);
        return {{4{p[11]}}, {4{p[7]}}, {4{p[3]}}};
    endfunction : idle_px
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // settle one step past the edge so registered outputs have landed
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : wt
    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    // ==========================================================
    // clock, reset, watchdog
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end
    initial begin
        rst_n_in = 1'b0;
        frame_start_in = 1'b0;
        orient_flip_in = 1'b0;
        partial_mode_in = 1'b0;
        line_in = 8'h00;
        pixel_in = 12'h000;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wt(2);
        chk(12'(ps), 12'h000);
        chk(12'(pe), 12'h000);
        chk(12'({tf, sl}), 12'h000);
        chk(12'(bf), 12'h053);
        chk(12'({top_p, bot_p}), 12'h001);
        chk(12'({pg, cl, wd, sc, bgr, vi, rd}), 12'h000);
        chk(12'(idle), 12'h000);
        $display("test reset done");
        // partial area with one surplus parameter
        a = 8'($random(seed));
        b = 8'($random(seed));
        i_lspa_host.send(PARTIAL_AREA_CMD, 3, {8'h00, ~a, b, a});
        wt(3);
        chk(12'(ps), 12'(a));
        chk(12'(pe), 12'(b));
        $display("test partial area done");
        for (int k = 0; k < 3; k++) begin
            a = (k == 0) ? 8'h00 : 8'($random(seed));
            b = (k == 1) ? 8'h00 : 8'($random(seed));
            m = 8'($random(seed));
            i_lspa_host.send(SCROLL_LAYOUT_CMD, 3, {8'h00, b, m, a});
            wt(3);
            chk(12'({tf, sl}), 12'({a, m}));
            chk(12'(bf), 12'(b));
            chk(12'({top_p, bot_p}), 12'({a != 8'h00, b != 8'h00}));
        end
        $display("test scroll layout done");
        for (int k = 0; k < 8; k++) begin
            o = k[0];
            m = 8'($random(seed)) & MAC_USED_MASK;
            m[4] = k[1];
            @(posedge clk_in) orient_flip_in <= o;
            i_lspa_host.send(MEM_ACCESS_CTRL_CMD, 1, {24'h000000, m});
            wt(6);
            chk(12'(pg), 12'(m[7] ^ o));
            chk(12'({cl, wd, bgr, vi}), 12'({m[6], m[5], m[3], m[0]}));
            chk(12'(sc), 12'(m[4] ^ o));
            chk(12'(rd), 12'(m[4] ^ m[0] ^ o));
            chk(12'(rot), 12'(m[4]));
        end
        @(posedge clk_in) orient_flip_in <= 1'b0;
        $display("test access control done");
        a = 8'($random(seed)) | 8'h01;
        i_lspa_host.send(SCROLL_START_CMD, 1, {24'h000000, a});
        wt(6);
        chk(12'(ss), 12'h000);
        chk(12'(sact), 12'h001);
        @(posedge clk_in) frame_start_in <= 1'b1;
        wt(3);
        @(posedge clk_in) frame_start_in <= 1'b0;
        wt(6);
        chk(12'(ss), 12'(a));
        i_lspa_host.send(NORMAL_MODE_CMD, 0, 32'h0);
        wt(3);
        chk(12'(sact), 12'h000);
        i_lspa_host.send(SCROLL_START_CMD, 1, {24'h000000, a});
        i_lspa_host.send(PARTIAL_MODE_CMD, 0, 32'h0);
        wt(3);
        chk(12'(sact), 12'h000);
        $display("test scroll start done");
        b = ps;
        i_lspa_host.send(TEST_A_CMD, 2, 32'h0000_5a5a);
        i_lspa_host.send(TEST_B_CMD, 1, 32'h0000_00ff);
        wt(4);
        chk(12'(ps), 12'(b));
        chk(12'(ss), 12'(a));
        $display("test reserved codes done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_in) pixel_in <= 12'($random(seed));
            i_lspa_host.send(REDUCED_COLOR_ON_CMD, 0, 32'h0);
            wt(4);
            chk(12'(idle), 12'h001);
            chk(px, idle_px(pixel_in));
            i_lspa_host.send(REDUCED_COLOR_OFF_CMD, 0, 32'h0);
            wt(4);
            chk(px, pixel_in);
        end
        $display("test idle done");
        i_lspa_host.send(PARTIAL_AREA_CMD, 2, 32'h0000_2010);
        partial_mode_in <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_in) line_in <= (k < 2) ? 8'h0f + 8'(k) : 8'h1e + 8'(k);
            wt(4);
            chk(12'({loff, ram_en}), (k == 0 || k == 3) ? 12'h002 : 12'h001);
        end
        @(posedge clk_in) partial_mode_in <= 1'b0;
        $display("test partial blanking done");
        close_out();
    end
endmodule : tb
